// >>> inc/safety_enable_map.svh
`ifndef SAFETY_ENABLE_MAP_SVH
`define SAFETY_ENABLE_MAP_SVH

// Test-pin detector window codes.
`define TP_BELOW   2'h0
`define TP_DEV     2'h1
`define TP_GAP     2'h2
`define TP_FORCED  2'h3

// Enable pin source selections.
`define EN_SRC_SW   1'h0
`define EN_SRC_ERR  1'h1

`define ONE_BIT_CLR 1'h0
`define ONE_BIT_SET 1'h1

`endif

// >>> inc/safety_enable_pkg.sv
package safety_enable_pkg;

  typedef enum logic [1:0] {
    MODE_PROBE  = 2'b00,
    MODE_NONE   = 2'b01,
    MODE_DEV    = 2'b11,
    MODE_FORCED = 2'b10
  } special_mode_t;

  typedef logic [1:0] test_window_t;

endpackage

// >>> verilog/arm_once.sv
`timescale 1ns/1ps
`include "safety_enable_map.svh"

// Single-shot latch: accepts one arming request, then locks until reset.
module arm_once (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic open_window,
  input  wire logic arm_req,
  output logic      armed,
  output logic      used
);

  logic armed_q;
  logic armed_d;
  logic used_q;
  logic used_d;

  always_comb begin
    armed_d = armed_q;
    used_d  = used_q;
    if (!used_q && open_window && arm_req) begin
      armed_d = `ONE_BIT_SET;
      used_d  = `ONE_BIT_SET;
    end else if (!open_window) begin
      // Once the start-up window has passed, no later write can arm.
      used_d = `ONE_BIT_SET;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      armed_q <= `ONE_BIT_CLR;
      used_q  <= `ONE_BIT_CLR;
    end else begin
      armed_q <= armed_d;
      used_q  <= used_d;
    end
  end

  assign armed = armed_q;
  assign used  = used_q;

endmodule

// >>> verilog/safety_enable.sv
`timescale 1ns/1ps
`include "safety_enable_map.svh"

// How it works
// - Enable pin follows the host-written enable request.
// - With the enable request selected, enable goes high only while the watchdog is served correctly.
// - Enable falls low at the clock edge after the system reset is asserted.
// - Enable low after power-up and in sleep or fail-safe mode.
// - When selected, the CAN failure flag drives the enable pin.
// - Failure output is active low, selected by the host-written cfg_err_select bit.
// - Forced-run window at supply-up enters forced run mode.
// - Forced run disables supervision and blocks every register access.
// - Forced run keeps regulators on and transceivers active.
// - Development window at supply-up enters development mode.
// - Test-pin below the development window or in the gap above it selects no special mode.
// - Development mode relaxes watchdog and interrupt supervision.
// - Pin-entered modes are left once the test pin leaves its window.
// - A control bit arms development mode once after battery power-on.
module safety_enable
  import safety_enable_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         resetn,
  input  wire logic         supply_up,
  input  wire test_window_t test_window,
  input  wire logic         cfg_write,
  input  wire logic         cfg_enable_req,
  input  wire logic         cfg_err_select,
  input  wire logic         cfg_dev_arm,
  input  wire logic         normal_mode,
  input  wire logic         watchdog_ok,
  input  wire logic         system_reset_low,
  input  wire logic         sleep_mode,
  input  wire logic         failsafe_mode,
  input  wire logic         bus_error_flag,
  output logic              enable_out,
  output logic              forced_run_mode,
  output logic              development_mode,
  output logic              access_block,
  output logic              supervision_off,
  output logic              relaxed_supervision,
  output logic              regulators_force_on,
  output logic              transceivers_force_active,
  output logic              err_select_state
);

  special_mode_t mode_q;
  special_mode_t mode_d;
  logic          en_req_q;
  logic          en_req_d;
  logic          err_sel_q;
  logic          err_sel_d;
  logic          en_pin_q;
  logic          en_pin_d;
  logic          fr_q;
  logic          fr_d;
  logic          dev_q;
  logic          dev_d;
  logic          blk_q;
  logic          blk_d;
  logic          sup_off_q;
  logic          sup_off_d;
  logic          relax_q;
  logic          relax_d;
  logic          reg_on_q;
  logic          reg_on_d;
  logic          trx_q;
  logic          trx_d;
  logic          soft_dev;
  logic          reg_write;

  function automatic logic in_forced(input test_window_t w);
    return w == `TP_FORCED;
  endfunction

  function automatic logic in_dev(input test_window_t w);
    return w == `TP_DEV;
  endfunction

  function automatic logic forced_mode(input special_mode_t m);
    return m == MODE_FORCED;
  endfunction

  function automatic logic dev_mode(input special_mode_t m);
    return m == MODE_DEV;
  endfunction

  // Register writes are refused entirely in forced run mode.
  assign reg_write = cfg_write && !forced_mode(mode_q);

  arm_once u_arm (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .open_window (!normal_mode),
    .arm_req     (reg_write && cfg_dev_arm),
    .armed       (soft_dev),
    .used        ()
  );

  // The pin is sampled on the first cycle the supply is seen up.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_PROBE: begin
        if (supply_up) begin
          if (in_forced(test_window)) begin
            mode_d = MODE_FORCED;
          end else if (in_dev(test_window)) begin
            mode_d = MODE_DEV;
          end else begin
            mode_d = MODE_NONE;
          end
        end
      end
      MODE_DEV: begin
        if (!in_dev(test_window)) begin
          mode_d = MODE_NONE;
        end
      end
      MODE_FORCED: begin
        if (!in_forced(test_window)) begin
          mode_d = MODE_NONE;
        end
      end
      default: begin
        mode_d = MODE_NONE;
      end
    endcase
  end

  always_comb begin
    en_req_d  = en_req_q;
    err_sel_d = err_sel_q;
    if (reg_write) begin
      en_req_d  = cfg_enable_req;
      err_sel_d = cfg_err_select;
    end
    if (!watchdog_ok && reg_write) begin
      // A high request made without watchdog service is dropped.
      en_req_d = `ONE_BIT_CLR;
    end
  end

  // The pin register sees the reset input combinationally so that the
  // low edge reaches the pin at the next clock; an async path would
  // violate the registered-output style.
  always_comb begin
    if (!system_reset_low || sleep_mode || failsafe_mode
        || mode_q == MODE_PROBE) begin
      en_pin_d = `ONE_BIT_CLR;
    end else if (err_sel_q == `EN_SRC_ERR) begin
      en_pin_d = !bus_error_flag;
    end else begin
      en_pin_d = en_req_q && watchdog_ok;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= MODE_PROBE;
    end else begin
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_req_q  <= `ONE_BIT_CLR;
      err_sel_q <= `EN_SRC_SW;
    end else begin
      en_req_q  <= en_req_d;
      err_sel_q <= err_sel_d;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en_pin_q <= `ONE_BIT_CLR;
    end else begin
      en_pin_q <= en_pin_d;
    end
  end

  // Mode outputs follow the next mode, so they change on the same edge
  // as the mode register instead of trailing it by a cycle.
  always_comb begin
    fr_d      = forced_mode(mode_d);
    blk_d     = forced_mode(mode_d);
    sup_off_d = forced_mode(mode_d);
    reg_on_d  = forced_mode(mode_d);
    trx_d     = forced_mode(mode_d);
    dev_d     = dev_mode(mode_d) || soft_dev;
    relax_d   = dev_mode(mode_d) || soft_dev;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fr_q      <= `ONE_BIT_CLR;
      dev_q     <= `ONE_BIT_CLR;
      blk_q     <= `ONE_BIT_CLR;
      sup_off_q <= `ONE_BIT_CLR;
      relax_q   <= `ONE_BIT_CLR;
      reg_on_q  <= `ONE_BIT_CLR;
      trx_q     <= `ONE_BIT_CLR;
    end else begin
      fr_q      <= fr_d;
      dev_q     <= dev_d;
      blk_q     <= blk_d;
      sup_off_q <= sup_off_d;
      relax_q   <= relax_d;
      reg_on_q  <= reg_on_d;
      trx_q     <= trx_d;
    end
  end

  assign enable_out                = en_pin_q;
  assign forced_run_mode           = fr_q;
  assign development_mode          = dev_q;
  assign access_block              = blk_q;
  assign supervision_off           = sup_off_q;
  assign relaxed_supervision       = relax_q;
  assign regulators_force_on       = reg_on_q;
  assign transceivers_force_active = trx_q;
  assign err_select_state          = err_sel_q;

endmodule

// >>> bench/safety_enable_checker.sv
`timescale 1ns/1ps
`include "safety_enable_map.svh"
module safety_enable_checker
  import safety_enable_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         resetn,
  input wire logic         supply_up,
  input wire test_window_t test_window,
  input wire logic         watchdog_ok,
  input wire logic         system_reset_low,
  input wire logic         sleep_mode,
  input wire logic         failsafe_mode,
  input wire logic         enable_out,
  input wire logic         forced_run_mode,
  input wire logic         development_mode,
  input wire logic         access_block,
  input wire logic         supervision_off,
  input wire logic         regulators_force_on,
  input wire logic         transceivers_force_active
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_wdog_gate: assert property (!watchdog_ok |=> !enable_out)
    else $error("enable high without watchdog service");
  a_reset_gate: assert property (!system_reset_low |=> !enable_out)
    else $error("enable high during system reset");
  a_sleep_gate: assert property ((sleep_mode || failsafe_mode) |=>
    !enable_out) else $error("enable high in sleep or fail-safe");
  a_forced_entry: assert property ($rose(supply_up) &&
    test_window == `TP_FORCED |-> ##[1:2] forced_run_mode)
    else $error("forced run not entered");
  a_dev_entry: assert property ($rose(supply_up) &&
    test_window == `TP_DEV |-> ##[1:2] development_mode)
    else $error("development mode not entered");
  a_forced_exit: assert property (forced_run_mode &&
    test_window != `TP_FORCED |-> ##[1:2] !forced_run_mode)
    else $error("forced run kept outside window");
  a_no_reentry: assert property ($fell(forced_run_mode) |=>
    !forced_run_mode [*8]) else $error("forced run re-entered");
  a_forced_outs: assert property (forced_run_mode |-> access_block &&
    supervision_off && regulators_force_on && transceivers_force_active)
    else $error("forced run outputs incomplete");
endmodule
bind safety_enable safety_enable_checker u_safety_enable_checker (.*);

// >>> bench/host_model.sv
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_sys,
  output logic      cfg_write,
  output logic      cfg_enable_req,
  output logic      cfg_err_select,
  output logic      cfg_dev_arm
);
  initial begin
    cfg_write      <= 1'h0;
    cfg_enable_req <= 1'h0;
    cfg_err_select <= 1'h0;
    cfg_dev_arm    <= 1'h0;
  end
  // Data lines are inverted between writes so stale values never help.
  task automatic wr(input logic en, input logic err, input logic arm);
    @(posedge clk_sys);
    cfg_write      <= 1'h1;
    cfg_enable_req <= en;
    cfg_err_select <= err;
    cfg_dev_arm    <= arm;
    @(posedge clk_sys);
    cfg_write      <= 1'h0;
    {cfg_enable_req, cfg_err_select, cfg_dev_arm} <= ~{en, err, arm};
  endtask
endmodule

// >>> bench/safety_enable_test.sv
`timescale 1ns/1ps
`include "safety_enable_map.svh"
module safety_enable_test;
  import safety_enable_pkg::*;
  logic         clk_sys = 1'h0;
  logic         resetn = 1'h0;
  logic         supply_up = 1'h0;
  logic         normal_mode = 1'h0;
  logic         bus_error_flag = 1'h0;
  logic [3:0]   cause = 4'h0;
  test_window_t test_window = `TP_BELOW;
  logic system_reset_low, sleep_mode, failsafe_mode, watchdog_ok;
  logic cfg_write, cfg_enable_req, cfg_err_select, cfg_dev_arm;
  logic enable_out, forced_run_mode, development_mode, access_block;
  logic supervision_off, relaxed_supervision, regulators_force_on;
  logic transceivers_force_active, err_select_state;
  int           fails = 0;
  int           check_count = 0;
  assign system_reset_low = ~cause[0];
  assign sleep_mode = cause[1];
  assign failsafe_mode = cause[2];
  assign watchdog_ok = ~cause[3];
  safety_enable u_safety_enable (.*);
  host_model u_host_model (.*);
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input logic got, input logic exp);
    if (got !== exp) begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      fails++;
    end
    check_count++;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic reset_dut(input test_window_t win);
    @(posedge clk_sys);
    {resetn, supply_up, normal_mode, cause} <= 7'h00;
    test_window <= win;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'h1;
  endtask
  task automatic supply_on;
    @(posedge clk_sys);
    supply_up <= 1'h1;
    step(3);
  endtask
  task automatic power_up(input test_window_t win);
    reset_dut(win);
    supply_on();
  endtask
  task automatic t_enable;
    // A request stored before the supply is seen must not reach the pin until the supply is up.
    reset_dut(`TP_GAP);
    u_host_model.wr(1'h1, 1'h0, 1'h0);
    step(2);
    chk(enable_out, 1'h0);
    supply_on();
    chk(enable_out, 1'h1);
    for (int i = 0; i < 4; i++) begin
      u_host_model.wr(1'h1, 1'h0, 1'h0);
      step(1);
      chk(enable_out, 1'h1);
      @(posedge clk_sys) cause <= 4'h1 << i;
      step(1);
      chk(enable_out, 1'h0);
      @(posedge clk_sys) cause <= 4'h0;
    end
    // A request made without watchdog service must not survive recovery.
    @(posedge clk_sys) cause <= 4'h8;
    u_host_model.wr(1'h1, 1'h0, 1'h0);
    cause <= 4'h0;
    step(3);
    chk(enable_out, 1'h0);
  endtask
  task automatic t_err;
    // The stored request is low, so a high pin can only be the flag.
    u_host_model.wr(1'h0, 1'h1, 1'h0);
    step(1);
    chk(err_select_state, 1'h1);
    chk(enable_out, 1'h1);
    @(posedge clk_sys) bus_error_flag <= 1'h1;
    step(1);
    chk(enable_out, 1'h0);
    @(posedge clk_sys) bus_error_flag <= 1'h0;
    step(1);
    chk(enable_out, 1'h1);
  endtask
  task automatic t_forced;
    power_up(`TP_FORCED);
    chk(forced_run_mode, 1'h1);
    chk(access_block, 1'h1);
    chk(supervision_off, 1'h1);
    chk(regulators_force_on, 1'h1);
    chk(transceivers_force_active, 1'h1);
    u_host_model.wr(1'h1, 1'h1, 1'h0);
    step(1);
    chk(err_select_state, 1'h0);
    chk(enable_out, 1'h0);
    @(posedge clk_sys) test_window <= `TP_GAP;
    step(2);
    chk(forced_run_mode, 1'h0);
    chk(supervision_off, 1'h0);
    @(posedge clk_sys) test_window <= `TP_FORCED;
    step(3);
    chk(forced_run_mode, 1'h0);
  endtask
  task automatic t_dev;
    power_up(`TP_DEV);
    chk(development_mode, 1'h1);
    chk(relaxed_supervision, 1'h1);
    chk(forced_run_mode, 1'h0);
    @(posedge clk_sys) test_window <= `TP_GAP;
    step(2);
    chk(development_mode, 1'h0);
    @(posedge clk_sys) test_window <= `TP_DEV;
    step(3);
    chk(relaxed_supervision, 1'h0);
    for (int i = 0; i < 2; i++) begin
      power_up(`TP_GAP);
      chk(development_mode, 1'h0);
      @(posedge clk_sys) normal_mode <= i[0];
      u_host_model.wr(1'h0, 1'h0, 1'h1);
      step(2);
      chk(development_mode, ~i[0]);
      chk(relaxed_supervision, ~i[0]);
    end
  endtask
  task automatic end_sim;
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #50000;
    fails++;
    end_sim();
  end
  initial begin
    t_enable();
    t_err();
    t_forced();
    t_dev();
    end_sim();
  end
endmodule
